// ### cidf_pkg.sv
// Shared constants and types for the identifier screening unit.
// Assumes nothing; every design file reads it through cidf_pkg::name.
package cidf_pkg;

	// ==========================================================
	// Lookup memory geometry
	localparam int LUT_WORDS = 512;
	localparam int LUT_AW = 9;
	localparam int PTR_W = 10;
	localparam int WORD_W = 32;
	localparam int IDX_W = 10;

	// ==========================================================
	// Entry field layout
	localparam int STD_KEY_W = 14;
	localparam int STD_ID_W = 11;
	localparam int EXT_ID_W = 29;
	localparam int CTRL_W = 3;
	localparam int HALF_W = 16;
	localparam int UP_CTRL_HI = 31;
	localparam int UP_CTRL_LO = 29;
	localparam int UP_DIS_BIT = 28;
	localparam int UP_ID_HI = 26;
	localparam int UP_ID_LO = 16;
	localparam int LO_CTRL_HI = 15;
	localparam int LO_CTRL_LO = 13;
	localparam int LO_DIS_BIT = 12;
	localparam int LO_ID_HI = 10;
	localparam logic [31:0] DIS_MASK = 32'h1000_1000;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
	localparam logic [31:0] ALL_ZERO = 32'h0000_0000;
	localparam logic [9:0] DIR_TABLE_START = 10'h000;

	// ==========================================================
	// Sequencer states and table selector
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SEL = 5'h02,
		ST_RD = 5'h04,
		ST_CHK = 5'h08,
		ST_DONE = 5'h10
	} cidf_state_t;

	typedef enum logic [4:0] {
		TB_DIR = 5'h01,
		TB_SIND = 5'h02,
		TB_SRNG = 5'h04,
		TB_EIND = 5'h08,
		TB_ERNG = 5'h10
	} cidf_tab_t;

endpackage : cidf_pkg

// ### cidf_lut_if.sv
// Interface between the screening sequencer and its lookup memory.
// Assumes both ends share sys_clk; carries a masked write and a read port.
`timescale 1ns/1ps
interface cidf_lut_if;
	logic wr_en;
	logic [cidf_pkg::LUT_AW-1:0] wr_addr;
	logic [cidf_pkg::WORD_W-1:0] wr_data;
	logic [cidf_pkg::WORD_W-1:0] wr_mask;
	logic rd_en;
	logic [cidf_pkg::LUT_AW-1:0] rd_addr;
	logic [cidf_pkg::WORD_W-1:0] rd_data;

	// ==========================================================
	// Views
	modport ctl (output wr_en, wr_addr, wr_data, wr_mask, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, wr_mask, rd_en, rd_addr, output rd_data);
endinterface : cidf_lut_if

// ### cidf_lut_mem.sv
// Lookup memory: bit-masked write port, registered read port.
// Assumes a single clock; contents are not reset, software loads them.
`timescale 1ns/1ps
module cidf_lut_mem #(
	parameter int WORDS = cidf_pkg::LUT_WORDS
) (
	input wire logic sys_clk, // Clock
	input wire logic nrst, // Async reset, low
	cidf_lut_if.mem lut // Memory side
);
	logic [cidf_pkg::WORD_W-1:0] mem_reg [WORDS];
	logic [cidf_pkg::WORD_W-1:0] rd_data_reg;
	logic [cidf_pkg::WORD_W-1:0] merged_next;

	// ==========================================================
	// Masked write: only bits under the mask change
	assign merged_next = (mem_reg[lut.wr_addr] & ~lut.wr_mask) | (lut.wr_data & lut.wr_mask);

	always_ff @(posedge sys_clk) begin
		if (lut.wr_en) begin
			mem_reg[lut.wr_addr] <= merged_next;
		end
	end

	// Read data held in a register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (lut.rd_en) begin
			rd_data_reg <= mem_reg[lut.rd_addr];
		end
	end

	assign lut.rd_data = rd_data_reg;
endmodule : cidf_lut_mem

// ### cidf_key_cmp.sv
// Compares one table entry key against the search key.
// Assumes both keys carry the controller number in their top bits.
`timescale 1ns/1ps
module cidf_key_cmp #(
	parameter int W = cidf_pkg::STD_KEY_W
) (
	input wire logic [W-1:0] entry, // Key held in the table
	input wire logic [W-1:0] key, // Key being searched
	output logic ent_eq, // Entry equals key
	output logic ent_gt // Entry above key
);
	// ==========================================================
	// Plain unsigned comparison
	assign ent_eq = (entry == key);
	assign ent_gt = (entry > key);
endmodule : cidf_key_cmp

// ### cidf_filter.sv
// Identifier screening unit shared by all controller receive sides.
// Assumes controllers raise id_valid for one cycle and wait for res_valid.
`timescale 1ns/1ps

module cidf_filter #(
	parameter int LUT_WORDS = cidf_pkg::LUT_WORDS
) (
	input wire logic sys_clk, // Clock, 10 MHz
	input wire logic nrst, // Async reset, low
	input wire logic filter_off, // Ignore all frames unless filter_bypass is set
	input wire logic filter_bypass, // Accept all frames
	input wire logic direct_store_enable, // Direct-store table in use
	input wire logic [9:0] std_individual_table_start, // Word address
	input wire logic [9:0] std_range_table_start, // Word address
	input wire logic [9:0] ext_individual_table_start, // Word address
	input wire logic [9:0] ext_range_table_start, // Word address
	input wire logic [9:0] end_of_tables, // Word address past last table
	input wire logic sw_wr_en, // Software memory write
	input wire logic [8:0] sw_wr_addr, // Word address
	input wire logic [31:0] sw_wr_data, // Write data
	input wire logic id_valid, // Controller has an identifier
	input wire logic [2:0] id_ctrl, // Controller number
	input wire logic id_ext, // Extended identifier
	input wire logic [28:0] id_value, // Identifier
	output logic busy, // Search in progress
	output logic res_valid, // Verdict pulse
	output logic res_accept, // Keep the frame
	output logic res_direct, // Direct-store hit
	output logic [9:0] res_index // Matched entry index
);
	// ==========================================================
	// State
	cidf_pkg::cidf_state_t state_reg, state_next;
	cidf_pkg::cidf_tab_t tab_reg, tab_next;
	logic [31:0] key_reg, key_next;
	logic [9:0] ptr_reg, ptr_next;
	logic [9:0] end_reg, end_next;
	logic [31:0] lo_bound_reg, lo_bound_next;
	logic acc_reg, acc_next;
	logic dir_reg, dir_next;
	logic [9:0] idx_reg, idx_next;
	logic busy_reg, res_valid_reg, res_accept_reg, res_direct_reg;
	logic [9:0] res_index_reg;
	logic req_ext_reg, req_ext_next;

	cidf_lut_if lut ();

	cidf_lut_mem #(.WORDS(LUT_WORDS)) u_mem (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.lut(lut)
	);

	// ==========================================================
	// Software write path with disable-bit protection
	wire screening = !filter_off && !filter_bypass;
	wire std_zone = {1'b0, sw_wr_addr} < ext_individual_table_start;
	wire range_zone = std_zone && ({1'b0, sw_wr_addr} >= std_range_table_start);
	wire range_cmd = range_zone && (sw_wr_data == cidf_pkg::ALL_ZERO
		|| sw_wr_data == cidf_pkg::ALL_ONES);
	wire [31:0] wr_mask_w = !screening ? cidf_pkg::ALL_ONES :
		(range_cmd ? cidf_pkg::DIS_MASK :
		(std_zone ? cidf_pkg::DIS_MASK : cidf_pkg::ALL_ZERO));

	assign lut.wr_en = sw_wr_en;
	assign lut.wr_addr = sw_wr_addr;
	assign lut.wr_data = sw_wr_data;
	assign lut.wr_mask = wr_mask_w;
	assign lut.rd_en = (state_reg == cidf_pkg::ST_RD);
	assign lut.rd_addr = ptr_reg[8:0];

	// ==========================================================
	// Table bounds for the table under search
	wire is_dir = (tab_reg == cidf_pkg::TB_DIR);
	wire is_sind = (tab_reg == cidf_pkg::TB_SIND);
	wire is_srng = (tab_reg == cidf_pkg::TB_SRNG);
	wire is_eind = (tab_reg == cidf_pkg::TB_EIND);
	wire is_erng = (tab_reg == cidf_pkg::TB_ERNG);
	wire [9:0] tab_start = is_dir ? cidf_pkg::DIR_TABLE_START :
		is_sind ? std_individual_table_start :
		is_srng ? std_range_table_start :
		is_eind ? ext_individual_table_start : ext_range_table_start;
	wire [9:0] tab_stop = is_dir ? std_individual_table_start :
		is_sind ? std_range_table_start :
		is_srng ? ext_individual_table_start :
		is_eind ? ext_range_table_start : end_of_tables;
	wire tab_empty = (tab_start == tab_stop) || (tab_start == end_of_tables);
	wire tab_last = is_srng || is_erng;
	wire [4:0] tab_succ = is_dir ? cidf_pkg::TB_SIND :
		is_sind ? cidf_pkg::TB_SRNG : cidf_pkg::TB_ERNG;

	// ==========================================================
	// Entry decode and comparison
	wire [31:0] rd = lut.rd_data;
	wire [13:0] up_key = {rd[31:29], rd[26:16]};
	wire [13:0] lo_key = {rd[15:13], rd[10:0]};
	wire up_dis = rd[cidf_pkg::UP_DIS_BIT];
	wire lo_dis = rd[cidf_pkg::LO_DIS_BIT];
	wire cu_eq, cu_gt, cl_eq, cl_gt, cx_eq, cx_gt, cb_eq, cb_gt;

	cidf_key_cmp #(.W(cidf_pkg::STD_KEY_W)) u_cmp_up (
		.entry(up_key),
		.key(key_reg[13:0]),
		.ent_eq(cu_eq),
		.ent_gt(cu_gt)
	);
	cidf_key_cmp #(.W(cidf_pkg::STD_KEY_W)) u_cmp_lo (
		.entry(lo_key),
		.key(key_reg[13:0]),
		.ent_eq(cl_eq),
		.ent_gt(cl_gt)
	);
	cidf_key_cmp #(.W(cidf_pkg::WORD_W)) u_cmp_ext (
		.entry(rd),
		.key(key_reg),
		.ent_eq(cx_eq),
		.ent_gt(cx_gt)
	);
	cidf_key_cmp #(.W(cidf_pkg::WORD_W)) u_cmp_bnd (
		.entry(lo_bound_reg),
		.key(key_reg),
		.ent_eq(cb_eq),
		.ent_gt(cb_gt)
	);

	// Per-table hit and early stop (tables ascend, so a larger entry ends the search)
	wire up_hit = !up_dis && cu_eq;
	wire lo_hit = !lo_dis && cl_eq;
	wire srng_hit = !(up_dis || lo_dis) && !cu_gt && (cl_gt || cl_eq);
	wire erng_odd = ptr_reg[0] ^ tab_start[0];
	wire erng_hit = erng_odd && !cb_gt && (cx_gt || cx_eq);
	wire word_hit = ((is_dir || is_sind) && (up_hit || lo_hit)) || (is_srng && srng_hit)
		|| (is_eind && cx_eq) || (is_erng && erng_hit);
	wire word_stop = ((is_dir || is_sind) && cl_gt) || (is_srng && cu_gt)
		|| (is_eind && cx_gt) || (is_erng && erng_odd && cb_gt);
	wire [9:0] ptr_inc = ptr_reg + 10'h001;
	wire [9:0] hit_idx = (is_dir || is_sind) ? {ptr_reg[8:0], !up_hit} : ptr_reg;
	wire [31:0] req_key = id_ext ? {id_ctrl, id_value} :
		{18'h0_0000, id_ctrl, id_value[10:0]};

	// ==========================================================
	// Search sequencer
	always_comb begin
		state_next = state_reg;
		tab_next = tab_reg;
		key_next = key_reg;
		ptr_next = ptr_reg;
		end_next = end_reg;
		lo_bound_next = lo_bound_reg;
		acc_next = acc_reg;
		dir_next = dir_reg;
		idx_next = idx_reg;
		req_ext_next = req_ext_reg;
		case (state_reg)
			cidf_pkg::ST_IDLE: begin
				if (id_valid) begin
					key_next = req_key;
					req_ext_next = id_ext;
					acc_next = 1'b0;
					dir_next = 1'b0;
					idx_next = 10'h000;
					if (filter_bypass) begin
						acc_next = 1'b1;
						state_next = cidf_pkg::ST_DONE;
					end else if (filter_off) begin
						state_next = cidf_pkg::ST_DONE;
					end else begin
						state_next = cidf_pkg::ST_SEL;
						if (id_ext) begin
							tab_next = cidf_pkg::TB_EIND;
						end else if (direct_store_enable) begin
							tab_next = cidf_pkg::TB_DIR;
						end else begin
							tab_next = cidf_pkg::TB_SIND;
						end
					end
				end
			end
			cidf_pkg::ST_SEL: begin
				if (!tab_empty) begin
					ptr_next = tab_start;
					end_next = tab_stop;
					state_next = cidf_pkg::ST_RD;
				end else if (tab_last) begin
					state_next = cidf_pkg::ST_DONE;
				end else begin
					tab_next = cidf_pkg::cidf_tab_t'(tab_succ);
				end
			end
			cidf_pkg::ST_RD: begin
				state_next = cidf_pkg::ST_CHK;
			end
			cidf_pkg::ST_CHK: begin
				if (is_erng && !erng_odd) begin
					lo_bound_next = rd;
				end
				if (word_hit) begin
					acc_next = 1'b1;
					dir_next = is_dir;
					idx_next = hit_idx;
					state_next = cidf_pkg::ST_DONE;
				end else if (word_stop || ptr_inc == end_reg) begin
					if (tab_last) begin
						state_next = cidf_pkg::ST_DONE;
					end else begin
						tab_next = cidf_pkg::cidf_tab_t'(tab_succ);
						state_next = cidf_pkg::ST_SEL;
					end
				end else begin
					ptr_next = ptr_inc;
					state_next = cidf_pkg::ST_RD;
				end
			end
			cidf_pkg::ST_DONE: begin
				state_next = cidf_pkg::ST_IDLE;
			end
			default: begin
				state_next = cidf_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= cidf_pkg::ST_IDLE;
			tab_reg <= cidf_pkg::TB_SIND;
			key_reg <= 32'h0000_0000;
			ptr_reg <= 10'h000;
			end_reg <= 10'h000;
			lo_bound_reg <= 32'h0000_0000;
			acc_reg <= 1'b0;
			dir_reg <= 1'b0;
			idx_reg <= 10'h000;
			req_ext_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tab_reg <= tab_next;
			key_reg <= key_next;
			ptr_reg <= ptr_next;
			end_reg <= end_next;
			lo_bound_reg <= lo_bound_next;
			acc_reg <= acc_next;
			dir_reg <= dir_next;
			idx_reg <= idx_next;
			req_ext_reg <= req_ext_next;
		end
	end

	// ==========================================================
	// Verdict outputs, all registered
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
			res_valid_reg <= 1'b0;
			res_accept_reg <= 1'b0;
			res_direct_reg <= 1'b0;
			res_index_reg <= 10'h000;
		end else begin
			busy_reg <= (state_next != cidf_pkg::ST_IDLE);
			res_valid_reg <= (state_reg == cidf_pkg::ST_DONE);
			if (state_reg == cidf_pkg::ST_DONE) begin
				res_accept_reg <= acc_reg;
				res_direct_reg <= dir_reg && !req_ext_reg;
				res_index_reg <= idx_reg;
			end
		end
	end

	assign busy = busy_reg;
	assign res_valid = res_valid_reg;
	assign res_accept = res_accept_reg;
	assign res_direct = res_direct_reg;
	assign res_index = res_index_reg;

	// ==========================================================
	// Assertions
	wire idle_req = (state_reg == cidf_pkg::ST_IDLE) && id_valid;

	a_bypass_accept: assert property (@(posedge sys_clk) disable iff (!nrst)
		idle_req && filter_bypass |=> ##1 res_valid && res_accept)
		else $error("bypass did not accept");
	a_off_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
		idle_req && filter_off && !filter_bypass |=> ##1 res_valid && !res_accept)
		else $error("filter off did not discard");
	a_dir_first: assert property (@(posedge sys_clk) disable iff (!nrst)
		idle_req && !filter_off && !filter_bypass && !id_ext && direct_store_enable
		|=> tab_reg == cidf_pkg::TB_DIR && state_reg == cidf_pkg::ST_SEL)
		else $error("direct table not searched first");
	a_ext_start: assert property (@(posedge sys_clk) disable iff (!nrst)
		idle_req && !filter_off && !filter_bypass && id_ext |=> tab_reg == cidf_pkg::TB_EIND)
		else $error("extended search began elsewhere");
	a_ext_no_direct: assert property (@(posedge sys_clk) disable iff (!nrst)
		res_valid && $past(req_ext_reg, 2) |-> !res_direct)
		else $error("extended frame marked direct-store");
	a_active_mask: assert property (@(posedge sys_clk) disable iff (!nrst)
		sw_wr_en && screening && !std_zone |-> lut.wr_mask == cidf_pkg::ALL_ZERO)
		else $error("extended table written while screening");
	a_range_mask: assert property (@(posedge sys_clk) disable iff (!nrst)
		sw_wr_en && screening && range_zone |-> lut.wr_mask == cidf_pkg::DIS_MASK)
		else $error("range write touched more than disable bits");
	a_empty_skip: assert property (@(posedge sys_clk) disable iff (!nrst)
		state_reg == cidf_pkg::ST_SEL && tab_empty |=> state_reg != cidf_pkg::ST_RD)
		else $error("empty table was read");
	a_hit_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
		state_reg == cidf_pkg::ST_CHK && word_hit |=> ##1 res_valid && res_accept
		&& res_index == $past(hit_idx, 2))
		else $error("hit not reported with its index");
	a_last_miss: assert property (@(posedge sys_clk) disable iff (!nrst)
		state_reg == cidf_pkg::ST_CHK && !word_hit && tab_last && word_stop
		|=> ##1 res_valid && !res_accept)
		else $error("miss in last table not discarded");
	a_pulse_once: assert property (@(posedge sys_clk) disable iff (!nrst)
		res_valid |-> !busy ##1 !res_valid)
		else $error("verdict longer than one cycle");

	c_std_hit: cover property (@(posedge sys_clk) disable iff (!nrst)
		res_valid && res_accept && !res_direct);
	c_direct_hit: cover property (@(posedge sys_clk) disable iff (!nrst)
		res_valid && res_direct);
	c_ext_range_hit: cover property (@(posedge sys_clk) disable iff (!nrst)
		state_reg == cidf_pkg::ST_CHK && is_erng && erng_hit);
	c_discard: cover property (@(posedge sys_clk) disable iff (!nrst)
		res_valid && !res_accept && !$past(filter_off, 2));
endmodule : cidf_filter

// ### cidf_ctrl_model.sv
// Receive side of one controller, seen from the screening unit.
// Assumes sys_clk and nrst of the unit; req is a one-cycle pulse.
`timescale 1ns/1ps
module cidf_ctrl_model (
	input wire logic sys_clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic req, // Identifier received
	input wire logic [2:0] req_ctrl, // Controller number
	input wire logic req_ext, // Extended size
	input wire logic [28:0] req_value, // Identifier
	input wire logic res_valid, // Verdict pulse
	output logic id_valid, // Signal to unit
	output logic [2:0] id_ctrl, // Controller number
	output logic id_ext, // Size
	output logic [28:0] id_value // Identifier
);
	logic pending;

	// ==========================================================
	// Signal one identifier, then wait for its verdict
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			id_valid <= 1'b0;
			id_ctrl <= 3'h0;
			id_ext <= 1'b0;
			id_value <= 29'h0;
			pending <= 1'b0;
		end else if (req && !pending) begin
			id_valid <= 1'b1;
			id_ctrl <= req_ctrl;
			id_ext <= req_ext;
			id_value <= req_value;
			pending <= 1'b1;
		end else begin
			id_valid <= 1'b0;
			// Fields no longer hold once taken
			if (id_valid) begin
				id_ctrl <= ~id_ctrl;
				id_ext <= ~id_ext;
				id_value <= ~id_value;
			end
			if (res_valid) pending <= 1'b0;
		end
	end
endmodule : cidf_ctrl_model

// ### can_identifier_acceptance_filter_tb_top.sv
// Self-checking bench for the identifier screening unit.
// Assumes cidf_pkg, cidf_lut_if and the design files compiled first.
`timescale 1ns/1ps
module can_identifier_acceptance_filter_tb_top;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic filter_off = 1'b0;
	logic filter_bypass = 1'b1;
	logic direct_store_enable = 1'b0;
	logic [9:0] sir_start = 10'h002;
	logic [9:0] srg_start = 10'h004;
	logic [9:0] eir_start = 10'h006;
	logic [9:0] erg_start = 10'h008;
	logic [9:0] eot = 10'h00a;
	logic sw_wr_en = 1'b0;
	logic [8:0] sw_wr_addr = 9'h000;
	logic [31:0] sw_wr_data = 32'h0;
	logic req = 1'b0;
	logic [2:0] req_ctrl = 3'h0;
	logic req_ext = 1'b0;
	logic [28:0] req_value = 29'h0;
	logic id_valid, id_ext, busy, res_valid, res_accept, res_direct;
	logic [2:0] id_ctrl;
	logic [28:0] id_value;
	logic [9:0] res_index;
	logic [11:0] exp_q [$]; // {accept, direct, index}
	logic [11:0] e;
	logic [31:0] tbl [10];
	int failures = 0;
	int compares = 0;

	// ==========================================================
	// Clock and instances
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	cidf_filter cidf_filter_inst (.sys_clk(sys_clk), .nrst(nrst), .filter_off(filter_off),
		.filter_bypass(filter_bypass), .direct_store_enable(direct_store_enable),
		.std_individual_table_start(sir_start), .std_range_table_start(srg_start),
		.ext_individual_table_start(eir_start), .ext_range_table_start(erg_start),
		.end_of_tables(eot), .sw_wr_en(sw_wr_en), .sw_wr_addr(sw_wr_addr),
		.sw_wr_data(sw_wr_data), .id_valid(id_valid), .id_ctrl(id_ctrl), .id_ext(id_ext),
		.id_value(id_value), .busy(busy), .res_valid(res_valid), .res_accept(res_accept),
		.res_direct(res_direct), .res_index(res_index));

	cidf_ctrl_model cidf_ctrl_model_inst (.sys_clk(sys_clk), .nrst(nrst), .req(req),
		.req_ctrl(req_ctrl), .req_ext(req_ext), .req_value(req_value), .res_valid(res_valid),
		.id_valid(id_valid), .id_ctrl(id_ctrl), .id_ext(id_ext), .id_value(id_value));

	// ==========================================================
	// Tasks
	task automatic print_verdict();
		$display("Counts: compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_wr_en <= 1'b1;
		sw_wr_addr <= a;
		sw_wr_data <= d;
		@(posedge sys_clk);
		sw_wr_en <= 1'b0;
	endtask : wr

	task automatic mode(input logic off, input logic bp, input logic dse);
		@(posedge sys_clk);
		filter_off <= off;
		filter_bypass <= bp;
		direct_store_enable <= dse;
	endtask : mode

	// Note the verdict, ask the controller model, wait for the answer
	task automatic screen(input logic [2:0] c, input logic x, input logic [28:0] v,
		input logic [11:0] ex);
		bit got;
		got = 0;
		exp_q.push_back(ex);
		@(posedge sys_clk);
		req <= 1'b1;
		req_ctrl <= c;
		req_ext <= x;
		req_value <= v;
		@(posedge sys_clk);
		req <= 1'b0;
		for (int n = 0; n < 1100 && !got; n++) @(negedge sys_clk) got = (res_valid === 1'b1);
		if (!got) begin
			failures++;
			$display("Error %0t: no verdict", $time);
		end
	endtask : screen

	// ==========================================================
	// Verdict monitor
	always @(negedge sys_clk) begin
		if (res_valid === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hfff;
			compares++;
			if ({res_accept, res_direct, res_index} !== e || busy !== 1'b0) begin
				failures++;
				$display("Error %0t: verdict %h expected %h", $time,
					{res_accept, res_direct, res_index}, e);
			end
		end
	end

	// ==========================================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("Error %0t: run too long", $time);
		print_verdict();
	end

	// ==========================================================
	// Tests
	initial begin
		tbl = '{32'h2010_2020, 32'h4005_4100, 32'h2030_2040, 32'h2050_67ff, 32'h2100_21ff,
			32'h4200_42ff, 32'h2001_0000, 32'h5000_0000, 32'h2100_0000, 32'h21ff_ffff};
		void'($urandom(20));
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (tbl[i]) wr(9'(i), tbl[i]);
		for (int i = 0; i < 4; i++) begin
			screen(3'($urandom_range(6, 1)), 1'($urandom), 29'($urandom), 12'h800);
		end
		mode(1'b1, 1'b1, 1'b0);
		screen(3'h3, 1'b0, 29'h123, 12'h800);
		mode(1'b1, 1'b0, 1'b0);
		screen(3'h1, 1'b0, 29'h040, 12'h000);
		mode(1'b0, 1'b0, 1'b1);
		screen(3'h1, 1'b0, 29'h020, 12'hc01);
		screen(3'h2, 1'b0, 29'h100, 12'hc03);
		screen(3'h1, 1'b0, 29'h040, 12'h805);
		// Low bits alias a direct entry, so a direct search would hit
		screen(3'h1, 1'b1, 29'h820, 12'h000);
		mode(1'b0, 1'b0, 1'b0);
		screen(3'h1, 1'b0, 29'h020, 12'h000);
		screen(3'h1, 1'b0, 29'h040, 12'h805);
		screen(3'h3, 1'b0, 29'h7ff, 12'h807);
		screen(3'h2, 1'b0, 29'h040, 12'h000);
		screen(3'h1, 1'b0, 29'h100, 12'h804);
		screen(3'h1, 1'b0, 29'h1ff, 12'h804);
		screen(3'h1, 1'b0, 29'h200, 12'h000);
		screen(3'h2, 1'b0, 29'h250, 12'h805);
		for (int i = 0; i < 3; i++) begin
			screen(3'h1, 1'b0, 29'h100 + 29'($urandom_range(255)), 12'h804);
		end
		screen(3'h1, 1'b1, 29'h0001_0000, 12'h806);
		screen(3'h2, 1'b1, 29'h0001_0000, 12'h000);
		screen(3'h1, 1'b1, 29'h0150_0000, 12'h809);
		screen(3'h1, 1'b1, 29'h01ff_ffff, 12'h809);
		screen(3'h1, 1'b1, 29'h0200_0000, 12'h000);
		wr(9'h002, 32'hffff_ffff);
		screen(3'h1, 1'b0, 29'h030, 12'h000);
		wr(9'h002, 32'h0000_0000);
		screen(3'h1, 1'b0, 29'h030, 12'h804);
		wr(9'h004, 32'hffff_ffff);
		screen(3'h1, 1'b0, 29'h150, 12'h000);
		wr(9'h004, 32'h0000_0000);
		screen(3'h1, 1'b0, 29'h150, 12'h804);
		wr(9'h006, 32'h0000_0000);
		screen(3'h1, 1'b1, 29'h0001_0000, 12'h806);
		@(posedge sys_clk) srg_start <= 10'h006;
		screen(3'h1, 1'b0, 29'h150, 12'h000);
		@(posedge sys_clk) srg_start <= 10'h004;
		eot <= 10'h008;
		screen(3'h1, 1'b1, 29'h0150_0000, 12'h000);
		repeat (4) @(posedge sys_clk);
		print_verdict();
	end
endmodule : can_identifier_acceptance_filter_tb_top
